/* verilog/hp_pkg.sv */
// Shared constants and types for the host control port front end
`default_nettype none
package hp_pkg;
   // Synchronised control pins travel together
   typedef struct packed {
      logic cs_n;
      logic strobe;
      logic rw_sdi;
      logic style;
      logic ser_sel;
   } hp_pins_t;

   localparam logic [4:0] HP_PINS_RST = 5'h1F;
   localparam int HP_ADDR_W = 11;
   localparam int HP_DATA_W = 8;
   localparam int HP_SH_W = 20;
   localparam int HP_CMD_RW_POS = 11;
   localparam int HP_FRAME_RW_POS = 19;
   localparam logic [4:0] HP_CMD_BITS = 5'h0C;
   localparam logic [4:0] HP_FRAME_BITS = 5'h14;
   localparam logic [4:0] HP_CNT_MAX = 5'h1F;
   localparam logic [7:0] HP_DATA_RST = 8'h00;

   typedef enum logic [1:0] {
      HP_IDLE = 2'b00,
      HP_RD_REQ = 2'b01,
      HP_RD_CAP = 2'b10,
      HP_RD_DRIVE = 2'b11
   } hp_state_t;
endpackage
`default_nettype wire

/* verilog/hp_host_port.sv */
// Host control port front end: parallel two-style bus or serial link
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] Serial select low: host port works as a parallel address/data bus.
// [R2] Serial select high: host port works as a serial link instead.
// [R3] Style low: shared strobe is an active-low data strobe qualifying accesses.
// [R4] Style high: shared strobe low is a read; device drives read data.
// [R5] Serial mode: shared strobe pin is the serial clock for both lines.
// [R6] Serial output changes only on serial clock falling edges.
// [R7] Serial input is sampled on serial clock rising edges.
// [R8] Host pulses chip select low per access, holds it until done.
// [R9] Style select is static: low strobe-qualified, high separate read/write.
// [R10] Strobe-qualified style: direction pin high reads, low writes.
// [R11] Separate-strobe style: write strobe low writes; device latches bus data.
// [R12] Serial mode ignores parallel strobes; parallel mode never sees a clock.
module hp_host_port
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic data_strobe_n,
   input wire logic rw_pin,
   input wire logic bus_style_select,
   input wire logic serial_host_select,
   input wire logic [10:0] addr_pin,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_n,
   output logic serial_out_line,
   output logic serial_out_oe_n,
   input wire logic [7:0] reg_rdata,
   output logic reg_rd,
   output logic reg_wr,
   output logic [10:0] reg_addr,
   output logic [7:0] reg_wdata
);
   hp_pkg::hp_pins_t pins_s1;
   hp_pkg::hp_pins_t pins_s2;
   hp_pkg::hp_pins_t pins_s3;
   logic [10:0] addr_s1;
   logic [10:0] addr_s2;
   logic [7:0] din_s1;
   logic [7:0] din_s2;
   hp_pkg::hp_state_t state;
   logic [19:0] sh_in;
   logic [4:0] bit_cnt;
   logic rise_d;
   logic ser_rd_act;
   logic ld1;
   logic ld2;
   logic [7:0] sout;
   logic [10:0] wr_addr;
   logic [7:0] wr_data;
   logic ser_sel;
   logic sel;
   logic sclk_rise;
   logic sclk_fall;
   logic rd_now;
   logic rd_start;
   logic wr_now;
   logic wr_end;
   logic ser_rd_evt;
   logic ser_wr_evt;

   // Parallel read condition per bus style
   function automatic logic par_read(input hp_pkg::hp_pins_t p);
      par_read = !p.ser_sel && !p.cs_n && !p.strobe && (p.style || p.rw_sdi);
   endfunction

   // Parallel write condition per bus style
   function automatic logic par_write(input hp_pkg::hp_pins_t p);
      par_write = !p.ser_sel && !p.cs_n && !p.rw_sdi && (p.style || !p.strobe);
   endfunction

   // Two-stage synchronisers for every pin
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pins_s1 <= hp_pkg::HP_PINS_RST;
         pins_s2 <= hp_pkg::HP_PINS_RST;
         pins_s3 <= hp_pkg::HP_PINS_RST;
         addr_s1 <= '0;
         addr_s2 <= '0;
         din_s1 <= hp_pkg::HP_DATA_RST;
         din_s2 <= hp_pkg::HP_DATA_RST;
      end
      else
      begin
         pins_s1 <= '{cs_n, data_strobe_n, rw_pin, bus_style_select, serial_host_select};
         pins_s2 <= pins_s1;
         pins_s3 <= pins_s2;
         addr_s1 <= addr_pin;
         addr_s2 <= addr_s1;
         din_s1 <= data_in;
         din_s2 <= din_s1;
      end
   end

   assign ser_sel = pins_s2.ser_sel;
   assign sel = !pins_s2.cs_n;
   assign sclk_rise = ser_sel && sel && pins_s2.strobe && !pins_s3.strobe; // R5 R12
   assign sclk_fall = ser_sel && sel && !pins_s2.strobe && pins_s3.strobe; // R5 R12
   assign rd_now = par_read(pins_s2); // R1 R3 R4 R12
   assign rd_start = rd_now && !par_read(pins_s3);
   assign wr_now = par_write(pins_s2); // R1 R3 R12
   assign wr_end = !wr_now && par_write(pins_s3);
   assign ser_rd_evt = rise_d && bit_cnt == hp_pkg::HP_CMD_BITS && sh_in[hp_pkg::HP_CMD_RW_POS];
   assign ser_wr_evt = rise_d && bit_cnt == hp_pkg::HP_FRAME_BITS
      && !sh_in[hp_pkg::HP_FRAME_RW_POS];

   // Parallel read sequencing
   always_ff @(posedge clk)
   begin
      if (rst)
         state <= hp_pkg::HP_IDLE;
      else
         case (state)
            hp_pkg::HP_IDLE: if (rd_start) state <= hp_pkg::HP_RD_REQ; // R4
            hp_pkg::HP_RD_REQ: state <= hp_pkg::HP_RD_CAP;
            hp_pkg::HP_RD_CAP: state <= rd_now ? hp_pkg::HP_RD_DRIVE : hp_pkg::HP_IDLE;
            hp_pkg::HP_RD_DRIVE: if (!rd_now) state <= hp_pkg::HP_IDLE;
            default: state <= hp_pkg::HP_IDLE;
         endcase
   end

   // Parallel data bus drive
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_out <= hp_pkg::HP_DATA_RST;
         data_oe_n <= 1'b1;
      end
      else
      begin
         if (state == hp_pkg::HP_RD_CAP)
            data_out <= reg_rdata;
         data_oe_n <= !(rd_now && (state == hp_pkg::HP_RD_CAP
            || state == hp_pkg::HP_RD_DRIVE)); // R1 R4
      end
   end

   // Parallel write latch while strobe is active
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_addr <= '0;
         wr_data <= hp_pkg::HP_DATA_RST;
      end
      else if (wr_now)
      begin
         wr_addr <= addr_s2;
         wr_data <= din_s2;
      end
   end

   // Serial input shifter
   always_ff @(posedge clk)
   begin
      if (rst || !sel || !ser_sel)
      begin
         sh_in <= '0;
         bit_cnt <= '0;
         rise_d <= 1'b0;
         ser_rd_act <= 1'b0;
      end
      else
      begin
         rise_d <= sclk_rise;
         // Read flag held for the frame; later rises move the command bit on
         if (ser_rd_evt)
            ser_rd_act <= 1'b1;
         if (sclk_rise)
         begin
            sh_in <= {sh_in[18:0], pins_s2.rw_sdi}; // R7
            if (bit_cnt != hp_pkg::HP_CNT_MAX)
               bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // Serial output shifter
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ld1 <= 1'b0;
         ld2 <= 1'b0;
         sout <= hp_pkg::HP_DATA_RST;
         serial_out_line <= 1'b0;
         serial_out_oe_n <= 1'b1;
      end
      else
      begin
         ld1 <= ser_rd_evt;
         ld2 <= ld1;
         if (!sel || !ser_sel)
            serial_out_oe_n <= 1'b1; // R1
         if (ld2)
            sout <= reg_rdata;
         else if (sclk_fall && ser_rd_act && bit_cnt < hp_pkg::HP_FRAME_BITS)
         begin
            serial_out_line <= sout[7]; // R6
            sout <= {sout[6:0], 1'b0};
            serial_out_oe_n <= 1'b0;
         end
      end
   end

   // Register-side strobes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reg_rd <= 1'b0;
         reg_wr <= 1'b0;
         reg_addr <= '0;
         reg_wdata <= hp_pkg::HP_DATA_RST;
      end
      else
      begin
         reg_rd <= rd_start || ser_rd_evt; // R2 R4 R5
         reg_wr <= wr_end || ser_wr_evt; // R2 R3 R5
         if (rd_start)
            reg_addr <= addr_s2;
         else if (ser_rd_evt)
            reg_addr <= sh_in[10:0];
         else if (ser_wr_evt)
            reg_addr <= sh_in[18:8];
         else if (wr_end)
            reg_addr <= wr_addr;
         if (ser_wr_evt)
            reg_wdata <= sh_in[7:0];
         else if (wr_end)
            reg_wdata <= wr_data;
      end
   end

   AST_SER_NO_BUS: assert property (@(posedge clk) disable iff (rst) // R2
      ser_sel |=> data_oe_n) else $error("Bus driven in serial mode");
   AST_PAR_NO_SOUT: assert property (@(posedge clk) disable iff (rst) // R1
      !ser_sel |=> serial_out_oe_n) else $error("Serial out driven in parallel mode");
   AST_SOUT_FALL: assert property (@(posedge clk) disable iff (rst) // R6
      $changed(serial_out_line) |-> $past(sclk_fall)) else $error("Serial out moved off fall");
   AST_SIN_RISE: assert property (@(posedge clk) disable iff (rst) // R7
      ($changed(bit_cnt) && bit_cnt != 5'h00) |-> $past(sclk_rise))
      else $error("Serial input sampled off rise");
   AST_RD_DRIVE: assert property (@(posedge clk) disable iff (rst) // R4
      rd_start ##1 rd_now ##1 rd_now |=> !data_oe_n && data_out == $past(reg_rdata))
      else $error("Read data not driven");
   AST_RD_PULSE: assert property (@(posedge clk) disable iff (rst) // R4
      rd_start |=> reg_rd ##1 !reg_rd) else $error("Read pulse wrong");
   AST_WR_STROBE: assert property (@(posedge clk) disable iff (rst) // R3
      wr_end |=> reg_wr && reg_wdata == $past(wr_data)) else $error("Write not issued");
   AST_DS_QUAL: assert property (@(posedge clk) disable iff (rst) // R3
      (rd_start && !pins_s2.style) |-> !pins_s2.strobe && pins_s2.rw_sdi)
      else $error("Read without data strobe");
   AST_SER_WR: assert property (@(posedge clk) disable iff (rst) // R5
      ser_wr_evt |=> reg_wr && reg_addr == $past(sh_in[18:8])) else $error("Serial write lost");
   AST_SER_PAR_ISO: assert property (@(posedge clk) disable iff (rst) // R12
      ser_sel |-> !rd_now && !wr_now) else $error("Parallel strobe seen in serial mode");
   COV_PAR_READ: cover property (@(posedge clk) disable iff (rst) rd_start ##3 !data_oe_n);
   COV_PAR_WRITE: cover property (@(posedge clk) disable iff (rst) wr_end ##1 reg_wr);
   COV_SER_READ: cover property (@(posedge clk) disable iff (rst) ld2 ##[1:40] !serial_out_oe_n);
   COV_SER_WRITE: cover property (@(posedge clk) disable iff (rst) ser_wr_evt);
endmodule // hp_host_port
`default_nettype wire

/* tb/hp_host_model.sv */
// Host model driving the control port pins
`timescale 1ns/100ps
`default_nettype none
module hp_host_model
(
   input wire logic clk,
   input wire logic serial_out_line,
   output logic cs_n,
   output logic sclk,
   output logic rw_sdi,
   output logic style,
   output logic ser_sel,
   output logic [10:0] addr,
   output logic [7:0] data_in
);
   initial
   begin
      cs_n = 1'h1;
      sclk = 1'h1;
      rw_sdi = 1'h1;
      style = 1'h0;
      ser_sel = 1'h0;
      addr = 11'h000;
      data_in = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One parallel access, held well past the sync lag
   task automatic par(input logic st, input logic rd, input logic [18:0] ad);
      tick(1);
      style = st;
      ser_sel = 1'h0;
      addr = ad[18:8];
      data_in = ad[7:0];
      tick(3);
      cs_n = 1'h0;
      tick(1);
      sclk = st & !rd;
      rw_sdi = rd;
      tick(9);
      sclk = 1'h1;
      rw_sdi = 1'h1;
      tick(2);
      cs_n = 1'h1;
      data_in = ~data_in;
      tick(4);
   endtask
   // Serial frame; clock idles high outside frames
   task automatic ser(input logic rd, input logic [18:0] ad, output logic [7:0] q);
      logic [19:0] f;
      f = {rd, ad};
      q = 8'h00;
      ser_sel = 1'h1;
      tick(4);
      cs_n = 1'h0;
      for (int i = 19; i >= 0; i--)
      begin
         sclk = 1'h0;
         if (!rd || i > 7) rw_sdi = f[i];
         tick(4);
         if (i < 8) q[i] = serial_out_line;
         sclk = 1'h1;
         tick(4);
      end
      cs_n = 1'h1;
      rw_sdi = ~rw_sdi;
      tick(4);
   endtask
endmodule // hp_host_model
`default_nettype wire

/* tb/host_port_mode_and_strobes_test.sv */
// Self-checking bench for the host control port front end
`timescale 1ns/100ps
`default_nettype none
module host_port_mode_and_strobes_test;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic cs_n, sclk, rw_sdi, style, ser_sel, so, so_oe_n, oe_n, rd, wr, so_prev;
   logic [10:0] addr, ra, wa;
   logic [7:0] din, dout, rdat = 8'h00, wd, rq, q;
   logic [3:0] rd_cnt, wr_cnt;
   logic oe_seen, so_seen;
   int errors = 0;
   int comparisons = 0;
   always #50 clk = ~clk;
   hp_host_port u_hp_host_port (.clk(clk), .rst(rst), .cs_n(cs_n), .data_strobe_n(sclk),
      .rw_pin(rw_sdi), .bus_style_select(style), .serial_host_select(ser_sel),
      .addr_pin(addr), .data_in(din), .data_out(dout), .data_oe_n(oe_n),
      .serial_out_line(so), .serial_out_oe_n(so_oe_n), .reg_rdata(rdat), .reg_rd(rd),
      .reg_wr(wr), .reg_addr(wa), .reg_wdata(wd));
   hp_host_model u_hp_host_model (.clk(clk), .serial_out_line(so), .cs_n(cs_n), .sclk(sclk),
      .rw_sdi(rw_sdi), .style(style), .ser_sel(ser_sel), .addr(addr), .data_in(din));
   always @(posedge clk)
   begin
      if (rd) rd_cnt <= rd_cnt + 4'h1;
      if (rd) ra <= wa;
      if (wr) wr_cnt <= wr_cnt + 4'h1;
      if (!oe_n) oe_seen <= 1'h1;
      if (!oe_n) rq <= dout;
      if (!so_oe_n) so_seen <= 1'h1;
      if (!rst && !so_oe_n && so !== so_prev && sclk) fail("serial out moved");
      so_prev <= so;
   end
   task automatic fail(input string m);
      errors++;
      $display("FAIL %0t %s", $time, m);
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask
   task automatic clr();
      rd_cnt = 4'h0;
      wr_cnt = 4'h0;
      oe_seen = 1'h0;
      so_seen = 1'h0;
   endtask
   task automatic xfer(input logic st, input logic r, input logic [18:0] ad);
      clr();
      u_hp_host_model.par(st, r, ad);
      if (r) chk({rd_cnt, wr_cnt, ra, 1'h0}, {8'h10, ad[18:8], 1'h0});
      if (r) chk({rq, oe_seen, so_seen}, {rdat, 1'h1, 1'h0});
      if (!r) chk({wr_cnt, rd_cnt, oe_seen, so_seen}, 10'h040);
      if (!r) chk({wa, wd}, ad);
   endtask
   task automatic test_strobe_style();
      xfer(1'h0, 1'h0, {11'h5A3, 8'hC6});
      rdat = 8'h3C;
      xfer(1'h0, 1'h1, {11'h7FF, 8'h00});
      $display("test_strobe_style done");
   endtask
   task automatic test_split_style();
      xfer(1'h1, 1'h0, {11'h001, 8'h81});
      rdat = 8'hA5;
      xfer(1'h1, 1'h1, {11'h400, 8'h00});
      $display("test_split_style done");
   endtask
   task automatic test_serial_read();
      clr();
      rdat = 8'h96;
      u_hp_host_model.ser(1'h1, {11'h2B7, 8'h00}, q);
      chk({rd_cnt, wr_cnt, ra, 1'h0}, {8'h10, 11'h2B7, 1'h0});
      chk({q, oe_seen, so_seen}, {8'h96, 1'h0, 1'h1});
      $display("test_serial_read done");
   endtask
   task automatic test_serial_write();
      clr();
      u_hp_host_model.ser(1'h0, {11'h6D1, 8'h4E}, q);
      chk({wr_cnt, rd_cnt, oe_seen, so_seen}, 10'h040);
      chk({wa, wd}, {11'h6D1, 8'h4E});
      $display("test_serial_write done");
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial
   begin
      clr();
      repeat (10) @(negedge clk);
      rst = 1'h0;
      test_strobe_style();
      test_serial_read();
      test_serial_write();
      test_split_style();
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fail("watchdog");
      stop_test();
   end
endmodule // host_port_mode_and_strobes_test
`default_nettype wire
